// *** design/flash_cmd_pkg.sv ***
package flash_cmd_pkg;
  localparam int unsigned ADDR_W = 17;
  localparam int unsigned DATA_W = 8;
  // unlock and command bytes
  localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
  localparam logic [7:0] UNLOCK2_DATA = 8'h55;
  localparam logic [7:0] AUTOSEL_DATA = 8'h90;
  localparam logic [7:0] PROGRAM_DATA = 8'hA0;
  localparam logic [7:0] ERASE_SETUP_DATA = 8'h80;
  localparam logic [7:0] CHIP_ERASE_DATA = 8'h10;
  localparam logic [7:0] SECTOR_ERASE_DATA = 8'h30;
  localparam logic [7:0] SUSPEND_DATA = 8'hB0;
  localparam logic [7:0] RESUME_DATA = 8'h30;
  localparam logic [7:0] RESET_DATA = 8'hF0;
  localparam logic [16:0] UNLOCK1_ADDR = 17'h00555;
  localparam logic [16:0] UNLOCK2_ADDR = 17'h002AA;
  localparam logic [16:0] DONT_CARE_ADDR = 17'h00000;
  // sector selector field
  localparam int unsigned SECTOR_LSB = 12;
  localparam int unsigned SECTOR_W = 5;
  // operation codes at the user port
  localparam logic [3:0] OP_READ = 4'h0;
  localparam logic [3:0] OP_RESET = 4'h1;
  localparam logic [3:0] OP_AUTOSEL = 4'h2;
  localparam logic [3:0] OP_PROGRAM = 4'h3;
  localparam logic [3:0] OP_CHIP_ERASE = 4'h4;
  localparam logic [3:0] OP_SECTOR_ERASE = 4'h5;
  localparam logic [3:0] OP_ADD_SECTOR = 4'h6;
  localparam logic [3:0] OP_SUSPEND = 4'h7;
  localparam logic [3:0] OP_RESUME = 4'h8;
  // bus cycle timing
  localparam int unsigned CLK_NS = 25;
  localparam int unsigned T_SETUP_NS = 30;
  localparam int unsigned T_PULSE_NS = 50;
  localparam int unsigned T_HOLD_NS = 30;
  localparam int unsigned T_SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned T_PULSE_CYC = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned T_HOLD_CYC = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  // gap limit between cycles of one sequence (longest, rounds down)
  localparam int unsigned T_GAP_MAX_US = 50;
  localparam int unsigned T_GAP_MAX_CYC = (T_GAP_MAX_US * 1000) / CLK_NS;
  // suspend latency
  localparam int unsigned T_SUSPEND_US = 20;
  localparam int unsigned T_SUSPEND_CYC = (T_SUSPEND_US * 1000) / CLK_NS;
  localparam logic [7:0] DATA_RESET_VAL = 8'h00;
  localparam int unsigned POLL_BIT = 7;
  localparam int unsigned TOGGLE_BIT = 6;
  localparam int unsigned TIMEOUT_BIT = 5;
  localparam int unsigned WINDOW_BIT = 3;
  localparam int unsigned SECTOR_TOGGLE_BIT = 2;
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_SETUP = 4'b0010,
    S_PULSE = 4'b0100,
    S_HOLD  = 4'b1000
  } cyc_state_t;
endpackage

// *** design/bus_cycle.sv ***
// one strobed bus cycle: setup, strobe low, hold; write or read
module bus_cycle (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        start,
  input  wire logic        is_write,
  output logic             ce_b,
  output logic             we_b,
  output logic             oe_b,
  output logic             sample,
  output logic             done
);
  flash_cmd_pkg::cyc_state_t state_reg;
  logic [3:0]                cnt_reg;
  logic                      wr_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= flash_cmd_pkg::S_IDLE;
      cnt_reg   <= 4'h0;
      wr_reg    <= 1'b0;
      ce_b      <= 1'b1;
      we_b      <= 1'b1;
      oe_b      <= 1'b1;
      sample    <= 1'b0;
      done      <= 1'b0;
    end else begin
      sample <= 1'b0;
      done   <= 1'b0;
      case (state_reg)
        flash_cmd_pkg::S_IDLE: begin
          if (start) begin
            wr_reg    <= is_write;
            ce_b      <= 1'b0;
            cnt_reg   <= 4'(flash_cmd_pkg::T_SETUP_CYC);
            state_reg <= flash_cmd_pkg::S_SETUP;
          end
        end
        flash_cmd_pkg::S_SETUP: begin
          if (cnt_reg > 4'h1) begin
            cnt_reg <= cnt_reg - 4'h1;
          end else begin
            // address is stable before the later falling strobe
            we_b      <= ~wr_reg;
            oe_b      <= wr_reg;
            cnt_reg   <= 4'(flash_cmd_pkg::T_PULSE_CYC);
            state_reg <= flash_cmd_pkg::S_PULSE;
          end
        end
        flash_cmd_pkg::S_PULSE: begin
          if (cnt_reg > 4'h1) begin
            cnt_reg <= cnt_reg - 4'h1;
          end else begin
            // we rises first; ce stays low so data holds past it
            we_b      <= 1'b1;
            oe_b      <= 1'b1;
            sample    <= ~wr_reg;
            cnt_reg   <= 4'(flash_cmd_pkg::T_HOLD_CYC);
            state_reg <= flash_cmd_pkg::S_HOLD;
          end
        end
        flash_cmd_pkg::S_HOLD: begin
          if (cnt_reg > 4'h1) begin
            cnt_reg <= cnt_reg - 4'h1;
          end else begin
            ce_b      <= 1'b1;
            done      <= 1'b1;
            state_reg <= flash_cmd_pkg::S_IDLE;
          end
        end
        default: state_reg <= flash_cmd_pkg::S_IDLE;
      endcase
    end
  end
endmodule

// *** design/flash_host_ctrl.sv ***
module flash_host_ctrl (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        req_valid,
  input  wire logic [3:0]  req_op,
  input  wire logic [16:0] req_addr,
  input  wire logic [7:0]  req_data,
  output logic             req_ready,
  output logic             rsp_valid,
  output logic [7:0]       rsp_data,
  output logic             seq_late,
  output logic [16:0]      flash_addr,
  output logic [7:0]       flash_dq_out,
  output logic             flash_dq_oe,
  input  wire logic [7:0]  flash_dq_in,
  output logic             flash_ce_b,
  output logic             flash_we_b,
  output logic             flash_oe_b
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0]  dq_meta_reg;
  logic [7:0]  dq_sync_reg;
  logic [2:0]  step_reg;
  logic [2:0]  last_reg;
  logic [3:0]  op_reg;
  logic [16:0] addr_reg;
  logic [7:0]  data_reg;
  logic        busy_reg;
  logic        cyc_start_reg;
  logic        cyc_write;
  logic        cyc_sample;
  logic        cyc_done;
  logic        sample_d_reg;
  logic [10:0] gap_reg;
  logic [16:0] step_addr;
  logic [7:0]  step_data;
  logic        ce_b_w;
  logic        we_b_w;
  logic        oe_b_w;

  bus_cycle u_cycle (
    .clk      (clk),
    .rst_b    (rst_b),
    .start    (cyc_start_reg),
    .is_write (cyc_write),
    .ce_b     (ce_b_w),
    .we_b     (we_b_w),
    .oe_b     (oe_b_w),
    .sample   (cyc_sample),
    .done     (cyc_done)
  );

  // read data comes from the pins: two flops before use
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dq_meta_reg <= flash_cmd_pkg::DATA_RESET_VAL;
      dq_sync_reg <= flash_cmd_pkg::DATA_RESET_VAL;
    end else begin
      dq_meta_reg <= flash_dq_in;
      dq_sync_reg <= dq_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequence tables
  always_comb begin
    step_addr = flash_cmd_pkg::DONT_CARE_ADDR;
    step_data = flash_cmd_pkg::RESET_DATA;
    case (step_reg)
      3'd0: begin
        step_addr = flash_cmd_pkg::UNLOCK1_ADDR;
        step_data = flash_cmd_pkg::UNLOCK1_DATA;
      end
      3'd1: begin
        step_addr = flash_cmd_pkg::UNLOCK2_ADDR;
        step_data = flash_cmd_pkg::UNLOCK2_DATA;
      end
      3'd2: begin
        step_addr = flash_cmd_pkg::UNLOCK1_ADDR;
        case (op_reg)
          flash_cmd_pkg::OP_AUTOSEL: step_data = flash_cmd_pkg::AUTOSEL_DATA;
          flash_cmd_pkg::OP_PROGRAM: step_data = flash_cmd_pkg::PROGRAM_DATA;
          default:                   step_data = flash_cmd_pkg::ERASE_SETUP_DATA;
        endcase
      end
      3'd3: begin
        // program location; autoselect ends with a read
        step_addr = flash_cmd_pkg::UNLOCK1_ADDR;
        step_data = flash_cmd_pkg::UNLOCK1_DATA;
        if (op_reg == flash_cmd_pkg::OP_PROGRAM || op_reg == flash_cmd_pkg::OP_AUTOSEL) begin
          step_addr = addr_reg;
          step_data = data_reg;
        end
      end
      3'd4: begin
        step_addr = flash_cmd_pkg::UNLOCK2_ADDR;
        step_data = flash_cmd_pkg::UNLOCK2_DATA;
      end
      3'd5: begin
        // sector field carried only where a sector is needed
        step_addr = flash_cmd_pkg::UNLOCK1_ADDR;
        step_data = flash_cmd_pkg::CHIP_ERASE_DATA;
        if (op_reg == flash_cmd_pkg::OP_SECTOR_ERASE) begin
          step_addr = addr_reg;
          step_data = flash_cmd_pkg::SECTOR_ERASE_DATA;
        end
      end
      default: begin
        step_addr = flash_cmd_pkg::DONT_CARE_ADDR;
        step_data = flash_cmd_pkg::RESET_DATA;
      end
    endcase
    // single-cycle orders: one cycle, address don't care except for read and add-sector
    case (op_reg)
      flash_cmd_pkg::OP_READ: begin
        step_addr = addr_reg;
        step_data = flash_cmd_pkg::DATA_RESET_VAL;
      end
      flash_cmd_pkg::OP_SUSPEND: begin
        step_addr = flash_cmd_pkg::DONT_CARE_ADDR;
        step_data = flash_cmd_pkg::SUSPEND_DATA;
      end
      flash_cmd_pkg::OP_RESUME: begin
        step_addr = flash_cmd_pkg::DONT_CARE_ADDR;
        step_data = flash_cmd_pkg::RESUME_DATA;
      end
      flash_cmd_pkg::OP_RESET: begin
        step_addr = flash_cmd_pkg::DONT_CARE_ADDR;
        step_data = flash_cmd_pkg::RESET_DATA;
      end
      // another sector inside the acceptance window
      flash_cmd_pkg::OP_ADD_SECTOR: begin
        step_addr = addr_reg;
        step_data = flash_cmd_pkg::SECTOR_ERASE_DATA;
      end
      default: begin
        step_addr = step_addr;
        step_data = step_data;
      end
    endcase
  end

  // only the read step of a read or autoselect is a read cycle
  assign cyc_write = !((op_reg == flash_cmd_pkg::OP_READ) ||
                       (op_reg == flash_cmd_pkg::OP_AUTOSEL && step_reg == 3'd3));

  ////////////////////////////////////////////////////////////////////////
  // order sequencing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_reg      <= 1'b0;
      step_reg      <= 3'd0;
      last_reg      <= 3'd0;
      op_reg        <= flash_cmd_pkg::OP_READ;
      addr_reg      <= 17'h00000;
      data_reg      <= flash_cmd_pkg::DATA_RESET_VAL;
      cyc_start_reg <= 1'b0;
      req_ready     <= 1'b0;
    end else begin
      cyc_start_reg <= 1'b0;
      req_ready     <= !busy_reg && !req_valid;
      if (!busy_reg && req_valid && req_ready) begin
        busy_reg      <= 1'b1;
        req_ready     <= 1'b0;
        op_reg        <= req_op;
        addr_reg      <= req_addr;
        data_reg      <= req_data;
        cyc_start_reg <= 1'b1;
        case (req_op)
          flash_cmd_pkg::OP_READ,
          flash_cmd_pkg::OP_RESET,
          flash_cmd_pkg::OP_SUSPEND,
          flash_cmd_pkg::OP_RESUME,
          flash_cmd_pkg::OP_ADD_SECTOR: begin
            step_reg <= 3'd6;
            last_reg <= 3'd6;
          end
          flash_cmd_pkg::OP_AUTOSEL,
          flash_cmd_pkg::OP_PROGRAM: begin
            step_reg <= 3'd0;
            last_reg <= 3'd3;
          end
          default: begin
            step_reg <= 3'd0;
            last_reg <= 3'd5;
          end
        endcase
      end else if (busy_reg && cyc_done) begin
        // next cycle follows at once, well inside the gap limit
        if (step_reg == last_reg) begin
          busy_reg <= 1'b0;
        end else begin
          step_reg      <= step_reg + 3'd1;
          cyc_start_reg <= 1'b1;
        end
      end
    end
  end

  // gap watchdog between cycles of one sequence
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gap_reg  <= 11'h000;
      seq_late <= 1'b0;
    end else begin
      if (!busy_reg || cyc_start_reg) begin
        gap_reg <= 11'h000;
      end else if (gap_reg != 11'(flash_cmd_pkg::T_GAP_MAX_CYC)) begin
        gap_reg <= gap_reg + 11'h001;
      end
      seq_late <= busy_reg && (gap_reg == 11'(flash_cmd_pkg::T_GAP_MAX_CYC));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pins and answer; all outputs from flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flash_addr   <= 17'h00000;
      flash_dq_out <= flash_cmd_pkg::DATA_RESET_VAL;
      flash_dq_oe  <= 1'b0;
      flash_ce_b   <= 1'b1;
      flash_we_b   <= 1'b1;
      flash_oe_b   <= 1'b1;
      rsp_valid    <= 1'b0;
      rsp_data     <= flash_cmd_pkg::DATA_RESET_VAL;
      sample_d_reg <= 1'b0;
    end else begin
      flash_ce_b <= ce_b_w;
      flash_we_b <= we_b_w;
      flash_oe_b <= oe_b_w;
      if (cyc_start_reg) begin
        flash_addr   <= step_addr;
        flash_dq_out <= step_data;
        flash_dq_oe  <= cyc_write;
      end else if (cyc_done) begin
        flash_dq_oe <= 1'b0;
      end
      // status or array byte returned as read
      rsp_valid <= cyc_done && busy_reg && (step_reg == last_reg);
      // synced pins lag two flops: take the byte one clock after the strobe rises
      sample_d_reg <= cyc_sample;
      if (sample_d_reg) begin
        rsp_data <= dq_sync_reg;
      end
    end
  end
endmodule

// *** bench/flash_host_monitor.sv ***
module flash_host_monitor (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic        rsp_valid,
  input wire logic        seq_late,
  input wire logic [16:0] flash_addr,
  input wire logic [7:0]  flash_dq_out,
  input wire logic        flash_dq_oe,
  input wire logic        flash_ce_b,
  input wire logic        flash_we_b,
  input wire logic        flash_oe_b
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////
  a_write_drives: assert property (
    !flash_we_b |-> flash_dq_oe && !flash_ce_b) else $error("write strobe without drive");
  a_read_released: assert property (
    !flash_oe_b |-> !flash_dq_oe && !flash_ce_b) else $error("read while driving bus");
  a_strobe_excl: assert property (
    !(!flash_we_b && !flash_oe_b)) else $error("write and read strobes together");
  a_pulse_width: assert property (
    $fell(flash_we_b) |=> !flash_we_b ##1 flash_we_b) else $error("write pulse not 2 clk");
  a_addr_held: assert property (
    !flash_ce_b && $past(!flash_ce_b) |-> $stable(flash_addr)) else $error("address moved");
  a_data_held: assert property (
    $rose(flash_we_b) |-> $stable(flash_dq_out) && flash_dq_oe) else $error("data moved");
  a_take_answer: assert property (
    req_valid && req_ready |=> !req_ready ##[4:70] rsp_valid) else $error("order not answered");
  a_no_late: assert property (
    !seq_late) else $error("sequence gap too long");
  a_idle_after: assert property (
    rsp_valid |-> flash_ce_b && flash_we_b && flash_oe_b) else $error("strobes busy at answer");
endmodule
bind flash_host_ctrl flash_host_monitor u_mon (
  .clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req_ready(req_ready),
  .rsp_valid(rsp_valid), .seq_late(seq_late), .flash_addr(flash_addr),
  .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_ce_b(flash_ce_b),
  .flash_we_b(flash_we_b), .flash_oe_b(flash_oe_b)
);

// *** bench/flash_dev_model.sv ***
module flash_dev_model #(
  parameter logic [7:0] MFR_ID  = 8'h5D, // arbitrary value
  parameter logic [7:0] DEV_ID  = 8'h6E, // arbitrary value
  parameter logic [7:0] CONT_ID = 8'h2B  // arbitrary value
) (
  input  wire logic [16:0] flash_addr,
  input  wire logic [7:0]  flash_dq_out,
  input  wire logic        flash_dq_oe,
  input  wire logic        flash_ce_b,
  input  wire logic        flash_we_b,
  input  wire logic        flash_oe_b,
  output logic [7:0]       dev_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [0:131071];
  bit          written [0:131071];
  logic [31:0] emask = 32'h0;
  logic [16:0] last_a, la;
  logic [7:0]  last_d, d, q = 8'h00;
  logic [4:0]  esec;
  logic        back = 1'b0;
  int          st = 0;
  int          n = 0;
  wire         wr_n = flash_ce_b | flash_we_b;
  wire         rd_n = flash_ce_b | flash_oe_b;
  // released bus shows the inverse so a stale byte never passes
  assign dev_q = rd_n ? ~q : q;
  always @(negedge wr_n) la = flash_addr;
  always @(negedge rd_n) begin
    if (st == 1)
      q = flash_addr[1:0] == 2'h0 ? MFR_ID : flash_addr[1:0] == 2'h1 ? DEV_ID :
          flash_addr[1:0] == 2'h3 ? CONT_ID : 8'h00;
    else if (st == 5 || (st > 1 && emask[flash_addr[16:12]]))
      q = st == 4 ? 8'h80 : 8'h00;
    else
      q = written[flash_addr] ? mem[flash_addr] : flash_addr[7:0] ^ 8'h5A;
  end
  always @(posedge wr_n) begin
    d = flash_dq_oe ? flash_dq_out : 8'h00;
    last_a = la;
    last_d = d;
    if (d == 8'hB0) begin
      if (st == 2 || st == 3) st = 4;
    end
    else if (st == 3 || st == 5) n = 0;
    // more sectors join inside the window
    else if (st == 2 && n == 0 && d == 8'h30) emask[la[16:12]] = 1'b1;
    else if (st == 4 && n == 0 && d == 8'h30) st = 3;
    else if (d == 8'hF0) begin
      n = 0;
      st = (st == 4 || back) ? 4 : 0;
      back = 1'b0;
    end
    else case (n)
      0: n = (d == 8'hAA && la[11:0] == 12'h555) ? 1 : 0;
      1: n = (d == 8'h55 && la[11:0] == 12'h2AA) ? 2 : 0;
      2: begin
        n = d == 8'hA0 ? 3 : (d == 8'h80 && st != 4) ? 4 : 0;
        if (d == 8'h90) begin
          back = back | (st == 4);
          st = 1;
        end
      end
      3: begin
        mem[la] = d;
        written[la] = 1'b1;
        n = 0;
      end
      4: n = d == 8'hAA ? 5 : 0;
      5: n = d == 8'h55 ? 6 : 0;
      default: begin
        n = 0;
        if (d == 8'h10) st = 5;
        if (d == 8'h30) begin
          st = 2;
          esec = la[16:12];
          emask = 32'h0;
          emask[la[16:12]] = 1'b1;
        end
      end
    endcase
  end
endmodule

// *** bench/test_flash_host_ctrl.sv ***
module test_flash_host_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        req_valid = 1'b0;
  logic [3:0]  req_op = 4'h0;
  logic [16:0] req_addr = 17'h00000;
  logic [7:0]  req_data = 8'h00;
  logic [7:0]  rsp_data, flash_dq_out, flash_dq_in, dev_q;
  logic [16:0] flash_addr;
  logic        req_ready, rsp_valid, seq_late, flash_dq_oe;
  logic        flash_ce_b, flash_we_b, flash_oe_b;
  int          bad_count = 0;
  int          compares = 0;
  int          cycles = 0;
  always #12.5 clk = ~clk;
  assign flash_dq_in = flash_dq_oe ? flash_dq_out : dev_q;
  flash_host_ctrl DUT (.clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req_op(req_op),
    .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .seq_late(seq_late), .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in),
    .flash_ce_b(flash_ce_b), .flash_we_b(flash_we_b), .flash_oe_b(flash_oe_b));
  flash_dev_model u_dev (.flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe), .flash_ce_b(flash_ce_b), .flash_we_b(flash_we_b),
    .flash_oe_b(flash_oe_b), .dev_q(dev_q));
  ////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic op(input logic [3:0] o, input logic [16:0] a, input logic [7:0] d);
    int k;
    req_op = o;
    req_addr = a;
    req_data = d;
    // ready only returns after a cycle with valid low
    for (k = 0; k < 99 && req_ready !== 1'b1; k++) @(negedge clk);
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    for (k = 0; k < 99 && rsp_valid !== 1'b1; k++) @(negedge clk);
    chk(rsp_valid, 17'h1);
  endtask
  task automatic rd(input logic [3:0] o, input logic [16:0] a, input logic [7:0] e);
    op(o, a, 8'h00);
    chk(rsp_data, e);
  endtask
  task automatic wrote(input logic [16:0] a, input logic [7:0] d);
    chk(u_dev.last_a, a);
    chk(u_dev.last_d, d);
  endtask
  function automatic logic [7:0] pat(input logic [16:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction
  ////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles <= cycles + 1;
    // sequence list takes about 600 cycles
    if (cycles == 6000) begin
      bad_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    rd(flash_cmd_pkg::OP_READ, 17'h01234, pat(17'h01234));
    op(flash_cmd_pkg::OP_RESUME, 17'h00000, 8'h00);
    rd(flash_cmd_pkg::OP_READ, 17'h01234, pat(17'h01234));
    op(flash_cmd_pkg::OP_PROGRAM, 17'h1F0AB, 8'h3C);
    wrote(17'h1F0AB, 8'h3C);
    rd(flash_cmd_pkg::OP_READ, 17'h1F0AB, 8'h3C);
    rd(flash_cmd_pkg::OP_AUTOSEL, 17'h00000, u_dev.MFR_ID);
    rd(flash_cmd_pkg::OP_AUTOSEL, 17'h00001, u_dev.DEV_ID);
    rd(flash_cmd_pkg::OP_AUTOSEL, 17'h00003, u_dev.CONT_ID);
    rd(flash_cmd_pkg::OP_AUTOSEL, 17'h05002, 8'h00);
    op(flash_cmd_pkg::OP_RESET, 17'h00000, 8'h00);
    wrote(17'h00000, 8'hF0);
    rd(flash_cmd_pkg::OP_READ, 17'h1F0AB, 8'h3C);
    op(flash_cmd_pkg::OP_SECTOR_ERASE, 17'h05123, 8'h00);
    chk(u_dev.esec, 17'h00005);
    chk(u_dev.last_d, 17'h00030);
    op(flash_cmd_pkg::OP_ADD_SECTOR, 17'h06000, 8'h00);
    chk(u_dev.last_a[16:12], 17'h00006);
    rd(flash_cmd_pkg::OP_READ, 17'h05ABC, 8'h00);
    rd(flash_cmd_pkg::OP_READ, 17'h06ABC, 8'h00);
    op(flash_cmd_pkg::OP_SUSPEND, 17'h00000, 8'h00);
    wrote(17'h00000, 8'hB0);
    rd(flash_cmd_pkg::OP_READ, 17'h05ABC, 8'h80);
    op(flash_cmd_pkg::OP_PROGRAM, 17'h0A010, 8'h96);
    rd(flash_cmd_pkg::OP_READ, 17'h0A010, 8'h96);
    rd(flash_cmd_pkg::OP_AUTOSEL, 17'h05000, u_dev.MFR_ID);
    op(flash_cmd_pkg::OP_RESET, 17'h00000, 8'h00);
    rd(flash_cmd_pkg::OP_READ, 17'h05ABC, 8'h80);
    op(flash_cmd_pkg::OP_RESUME, 17'h00000, 8'h00);
    wrote(17'h00000, 8'h30);
    rd(flash_cmd_pkg::OP_READ, 17'h05ABC, 8'h00);
    op(flash_cmd_pkg::OP_PROGRAM, 17'h10000, 8'h77);
    op(flash_cmd_pkg::OP_CHIP_ERASE, 17'h00000, 8'h00);
    chk(u_dev.last_d, 17'h00010);
    rd(flash_cmd_pkg::OP_READ, 17'h10000, pat(17'h10000));
    op(flash_cmd_pkg::OP_SUSPEND, 17'h00000, 8'h00);
    rd(flash_cmd_pkg::OP_READ, 17'h05ABC, 8'h80);
    op(flash_cmd_pkg::OP_RESUME, 17'h00000, 8'h00);
    op(flash_cmd_pkg::OP_RESUME, 17'h00000, 8'h00);
    rd(flash_cmd_pkg::OP_READ, 17'h05ABC, 8'h00);
    chk(seq_late, 17'h0);
    wrap_up();
  end
endmodule
